// ---- src/mppio_top.sv ----
// Pin ports C to G with data latches and direction control (except input-only port F), and peripheral sharing.
//
// Implementation choice: the AHB-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module mppio_top
    import mppio_pkg::*;
(
    input  wire logic        i_sys_clk,
    input  wire logic        i_arst_n,
    // AHB-Lite slave.
    input  wire logic        i_hsel,
    input  wire logic [31:0] i_haddr,
    input  wire logic [1:0]  i_htrans,
    input  wire logic        i_hwrite,
    input  wire logic [2:0]  i_hsize,
    input  wire logic [31:0] i_hwdata,
    input  wire logic        i_hready,
    output logic      [31:0] o_hrdata,
    output logic             o_hreadyout,
    output logic             o_hresp,
    // Pins; the enable is high while the block drives the pin.
    input  wire logic [7:0]  i_pc_in,
    output logic      [7:0]  o_pc_out,
    output logic      [7:0]  o_pc_oe,
    output logic      [7:0]  o_pc_pullup,
    input  wire logic [7:0]  i_pd_in,
    output logic      [7:0]  o_pd_out,
    output logic      [7:0]  o_pd_oe,
    input  wire logic [7:0]  i_pe_in,
    output logic      [7:0]  o_pe_out,
    output logic      [7:0]  o_pe_oe,
    input  wire logic [7:0]  i_pf_in,
    input  wire logic [7:0]  i_pg_in,
    output logic      [7:0]  o_pg_out,
    output logic      [7:0]  o_pg_oe,
    output logic      [7:0]  o_pg_pullup,
    // Timer side.
    input  wire logic        i_timer_event_output_en,
    input  wire logic        i_timer_event_output,
    input  wire logic        i_timer_compare_output,
    output logic             o_timer_event_input,
    output logic             o_timer_capture_input,
    // External interrupt inputs, PC7 in bit 1 and PC6 in bit 0.
    output logic      [1:0]  o_ext_irq_level,
    // First serial interface.
    input  wire logic        i_first_serial_enable,
    input  wire logic        i_first_serial_master_select,
    input  wire logic        i_first_serial_clock,
    input  wire logic        i_first_serial_out,
    output logic             o_first_serial_clock_in,
    output logic             o_first_serial_in,
    // Second serial interface.
    input  wire logic        i_second_serial_enable,
    input  wire logic        i_second_serial_master_select,
    input  wire logic        i_second_serial_clock,
    input  wire logic        i_second_serial_out,
    output logic             o_second_serial_clock_in,
    output logic             o_second_serial_in,
    // PWM channels for PG7..PG4, channel 3 on PG7.
    input  wire logic [3:0]  i_pwm_en,
    input  wire logic [3:0]  i_pwm_level,
    // Option map select, for the rest of the chip.
    output logic             o_option_map_select
);

    mppio_state_t q;        // Registered state.
    mppio_state_t d;        // Next state.

    logic       addr_ok;    // Address lies inside the block window.
    logic       take;       // Address phase accepted this cycle.
    logic [3:0] a_idx;      // Index of the accepted address.
    logic [7:0] rd_val;     // Read value for the accepted address.
    logic [7:0] rd_c;       // Port C read view.
    logic [7:0] rd_g;       // Port G read view.
    logic [7:0] agree;      // Helper for the input filter.

    // Peripheral takeover: pin taken, drive wanted, level.
    logic [7:0] c_own;
    logic [7:0] c_own_out;
    logic [7:0] c_own_val;
    logic [7:0] c_drive;    // Effective output direction.
    logic [7:0] c_val;      // Level offered to the pin.
    logic [7:0] c_odm;      // Effective open-drain mask.
    logic [7:0] g_own;
    logic [7:0] g_own_out;
    logic [7:0] g_own_val;
    logic [7:0] g_drive;
    logic [7:0] g_val;
    logic [7:0] g_odm;
    logic [7:0] g_pum;      // Pullup request per bit, from the nibble bits.

    // Zero-wait slave that always answers OKAY.
    assign o_hreadyout = 1'b1;
    assign o_hresp     = 1'b0;
    assign o_hrdata    = {24'h000000, q.rdata};
    assign o_option_map_select = q.opt_map;

    // The block decodes the low 64 bytes only.
    assign addr_ok = (i_haddr[31:6] == 26'h0000000);
    assign take    = i_hsel & i_hready & i_htrans[1];
    assign a_idx   = i_haddr[5:2];

    // Port C peripheral ownership.
    always_comb begin
        c_own     = 8'h00;
        c_own_out = 8'h00;
        c_own_val = 8'h00;
        // Event output takes PC5 only while enabled.
        c_own[5]     = i_timer_event_output_en;
        c_own_out[5] = 1'b1;
        c_own_val[5] = i_timer_event_output;
        // PC4 and PC3 are never taken over; timer inputs just listen.
        if (i_first_serial_enable) begin
            c_own[2:0]     = 3'b111;
            // Clock drives for a master only.
            c_own_out[2:0] = {i_first_serial_master_select, 1'b1, 1'b0};
            c_own_val[2:0] = {i_first_serial_clock, i_first_serial_out, 1'b0};
        end
    end

    // Port G peripheral ownership.
    always_comb begin
        g_own     = 8'h00;
        g_own_out = 8'h00;
        g_own_val = 8'h00;
        g_own[7:4]     = i_pwm_en;
        g_own_out[7:4] = 4'hf;
        g_own_val[7:4] = i_pwm_level;
        // PG3 as output carries the compare level.
        g_own[3]     = q.dir[MPPIO_P_G][3];
        g_own_out[3] = 1'b1;
        g_own_val[3] = i_timer_compare_output;
        if (i_second_serial_enable) begin
            g_own[2:0]     = 3'b111;
            g_own_out[2:0] = {i_second_serial_master_select, 1'b1, 1'b0};
            g_own_val[2:0] = {i_second_serial_clock, i_second_serial_out, 1'b0};
        end
    end

    // Owned pins follow the peripheral, the rest follow direction and latch.
    // Stored directions stay as written.
    assign c_drive = (c_own & c_own_out) | (~c_own & q.dir[MPPIO_P_C]);
    assign c_val   = (c_own & c_own_val) | (~c_own & q.latch[MPPIO_P_C]);
    assign g_drive = (g_own & g_own_out) | (~g_own & q.dir[MPPIO_P_G]);
    assign g_val   = (g_own & g_own_val) | (~g_own & q.latch[MPPIO_P_G]);

    // PC7/6 are open-drain always, so a latch low can pull the interrupt line.
    assign c_odm = {2'b11, q.c_od[5:0]};
    assign g_odm = {{4{q.nib[MPPIO_NIB_G_UPPER_OD_BIT]}},
                    {4{q.nib[MPPIO_NIB_G_LOWER_OD_BIT]}}};
    assign g_pum = {{4{q.nib[MPPIO_NIB_G_UPPER_PU_BIT]}},
                    {4{q.nib[MPPIO_NIB_G_LOWER_PU_BIT]}}};

    // Open-drain bits release the pin for a high level.
    assign o_pc_out = c_val;
    assign o_pc_oe  = c_drive & ~(c_odm & c_val);
    assign o_pg_out = g_val;
    assign o_pg_oe  = g_drive & ~(g_odm & g_val);

    // Pullups drop on any pin driven low.
    assign o_pc_pullup = q.c_pu & ~(c_drive & ~c_val);
    assign o_pg_pullup = g_pum & ~(g_drive & ~g_val);

    // Ports D and E are plain push-pull ports.
    assign o_pd_out = q.latch[MPPIO_P_D];
    assign o_pd_oe  = q.dir[MPPIO_P_D];
    assign o_pe_out = q.latch[MPPIO_P_E];
    assign o_pe_oe  = q.dir[MPPIO_P_E];

    // Peripheral inputs see filtered pins in any direction.
    assign o_ext_irq_level          = q.filt[MPPIO_P_C][7:6];
    assign o_timer_event_input      = q.filt[MPPIO_P_C][4];
    assign o_timer_capture_input    = q.filt[MPPIO_P_C][3];
    assign o_first_serial_clock_in  = q.filt[MPPIO_P_C][2];
    assign o_first_serial_in        = q.filt[MPPIO_P_C][0];
    assign o_second_serial_clock_in = q.filt[MPPIO_P_G][2];
    assign o_second_serial_in       = q.filt[MPPIO_P_G][0];

    // Next-state logic: pin filters, data-phase writes, address-phase reads.
    always_comb begin
        d     = q;
        agree = 8'h00;
        rd_c  = 8'h00;
        rd_g  = 8'h00;
        rd_val = 8'h00;

        // Pins are asynchronous; a level counts once stages two and three agree.
        d.s1 = {i_pf_in, i_pg_in, i_pe_in, i_pd_in, i_pc_in};
        d.s2 = q.s1;
        d.s3 = q.s2;
        for (int p = 0; p < 5; p++) begin
            agree     = ~(q.s2[p] ^ q.s3[p]);
            d.filt[p] = (agree & q.s3[p]) | (~agree & q.filt[p]);
        end

        // Write data phase; hwdata is valid only now.
        if (q.wr_pend) begin
            if (q.opt_map) begin
                // Option map: low indices are directions.
                case (q.wr_idx)
                    MPPIO_IDX_C_DIR: d.dir[MPPIO_P_C] = i_hwdata[7:0];
                    MPPIO_IDX_D_DIR: d.dir[MPPIO_P_D] = i_hwdata[7:0];
                    MPPIO_IDX_E_DIR: d.dir[MPPIO_P_E] = i_hwdata[7:0];
                    MPPIO_IDX_G_DIR: d.dir[MPPIO_P_G] = i_hwdata[7:0];
                    default: begin
                    end
                endcase
            end else begin
                // Normal map: latches take writes, owned or not.
                case (q.wr_idx)
                    MPPIO_IDX_C_DATA: d.latch[MPPIO_P_C] = i_hwdata[7:0];
                    MPPIO_IDX_D_DATA: d.latch[MPPIO_P_D] = i_hwdata[7:0];
                    MPPIO_IDX_E_DATA: d.latch[MPPIO_P_E] = i_hwdata[7:0];
                    MPPIO_IDX_G_DATA: d.latch[MPPIO_P_G] = i_hwdata[7:0];
                    // Port F has nothing to store.
                    MPPIO_IDX_F_LEVELS: begin
                    end
                    default: begin
                    end
                endcase
            end
            // Control registers answer in both maps.
            case (q.wr_idx)
                MPPIO_IDX_CONFIG: d.opt_map = i_hwdata[MPPIO_CFG_OPTION_MAP_BIT];
                MPPIO_IDX_C_PULLUP: d.c_pu = i_hwdata[7:0];
                MPPIO_IDX_C_OD: d.c_od = i_hwdata[7:0];
                MPPIO_IDX_NIBBLE: d.nib = i_hwdata[3:0];
                default: begin
                end
            endcase
        end

        // Reads use next-state values, so a read after a write sees it.
        // Inputs show the pin, outputs the latch.
        rd_c = (d.dir[MPPIO_P_C] & d.latch[MPPIO_P_C])
             | (~d.dir[MPPIO_P_C] & q.filt[MPPIO_P_C]);
        rd_g = (d.dir[MPPIO_P_G] & d.latch[MPPIO_P_G])
             | (~d.dir[MPPIO_P_G] & q.filt[MPPIO_P_G]);
        // PG3 always reads the pin.
        rd_g[3] = q.filt[MPPIO_P_G][3];

        if (d.opt_map) begin
            case (a_idx)
                MPPIO_IDX_C_DIR: rd_val = d.dir[MPPIO_P_C];
                MPPIO_IDX_D_DIR: rd_val = d.dir[MPPIO_P_D];
                MPPIO_IDX_E_DIR: rd_val = d.dir[MPPIO_P_E];
                MPPIO_IDX_G_DIR: rd_val = d.dir[MPPIO_P_G];
                default:         rd_val = 8'h00;
            endcase
        end else begin
            case (a_idx)
                MPPIO_IDX_C_DATA: rd_val = rd_c;
                MPPIO_IDX_D_DATA: rd_val = (d.dir[MPPIO_P_D] & d.latch[MPPIO_P_D])
                                         | (~d.dir[MPPIO_P_D] & q.filt[MPPIO_P_D]);
                MPPIO_IDX_E_DATA: rd_val = (d.dir[MPPIO_P_E] & d.latch[MPPIO_P_E])
                                         | (~d.dir[MPPIO_P_E] & q.filt[MPPIO_P_E]);
                MPPIO_IDX_F_LEVELS: rd_val = q.filt[MPPIO_P_F];
                MPPIO_IDX_G_DATA: rd_val = rd_g;
                default:          rd_val = 8'h00;
            endcase
        end
        case (a_idx)
            MPPIO_IDX_CONFIG: rd_val = {7'h00, d.opt_map};
            MPPIO_IDX_C_PULLUP: rd_val = d.c_pu;
            MPPIO_IDX_C_OD: rd_val = d.c_od;
            MPPIO_IDX_NIBBLE: rd_val = {4'h0, d.nib};
            default: begin
            end
        endcase
        // Unmapped addresses read zero, no aliasing.
        if (!addr_ok) begin
            rd_val = 8'h00;
        end

        // Address phase: note writes, capture read data.
        d.wr_pend = take & i_hwrite & addr_ok;
        d.wr_idx  = a_idx;
        if (take && !i_hwrite) begin
            d.rdata = rd_val;
        end
    end

    // State register; pins come up as inputs.
    // Latches are undefined at reset; zero serves.
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q.wr_pend <= 1'b0;
            q.wr_idx  <= 4'h0;
            q.rdata   <= 8'h00;
            q.opt_map <= 1'b0;
            q.latch   <= {4{MPPIO_LATCH_RESET}};
            q.dir     <= {4{MPPIO_DIR_RESET}};
            q.c_pu    <= MPPIO_CTL_RESET;
            q.c_od    <= MPPIO_CTL_RESET;
            q.nib     <= MPPIO_NIB_RESET;
            q.s1      <= 40'h0000000000;
            q.s2      <= 40'h0000000000;
            q.s3      <= 40'h0000000000;
            q.filt    <= 40'h0000000000;
        end else begin
            q <= d;
        end
    end

endmodule
`default_nettype wire

// ---- shared/mppio_pkg.sv ----
// Register map, fields, reset values and state type of the pin ports.
`default_nettype none
package mppio_pkg;
    // Register indices; byte address is four times the index.
    localparam logic [3:0] MPPIO_IDX_C_DATA   = 4'h2;
    localparam logic [3:0] MPPIO_IDX_D_DATA   = 4'h3;
    localparam logic [3:0] MPPIO_IDX_E_DATA   = 4'h4;
    localparam logic [3:0] MPPIO_IDX_F_LEVELS = 4'h5;
    localparam logic [3:0] MPPIO_IDX_G_DATA   = 4'h6;
    // Direction registers reuse data indices in the option map.
    localparam logic [3:0] MPPIO_IDX_C_DIR    = 4'h2;
    localparam logic [3:0] MPPIO_IDX_D_DIR    = 4'h3;
    localparam logic [3:0] MPPIO_IDX_E_DIR    = 4'h4;
    localparam logic [3:0] MPPIO_IDX_G_DIR    = 4'h6;
    // Control registers reachable in both maps.
    localparam logic [3:0] MPPIO_IDX_CONFIG   = 4'h8;
    localparam logic [3:0] MPPIO_IDX_C_PULLUP = 4'h9;
    localparam logic [3:0] MPPIO_IDX_C_OD     = 4'ha;
    localparam logic [3:0] MPPIO_IDX_NIBBLE   = 4'hb;
    // Field positions.
    localparam int MPPIO_CFG_OPTION_MAP_BIT = 0;
    localparam int MPPIO_NIB_G_UPPER_PU_BIT = 0;
    localparam int MPPIO_NIB_G_LOWER_PU_BIT = 1;
    localparam int MPPIO_NIB_G_UPPER_OD_BIT = 2;
    localparam int MPPIO_NIB_G_LOWER_OD_BIT = 3;
    // Reset values.
    localparam logic [7:0] MPPIO_DIR_RESET   = 8'h00;
    localparam logic [7:0] MPPIO_LATCH_RESET = 8'h00;
    localparam logic [7:0] MPPIO_CTL_RESET   = 8'h00;
    localparam logic [3:0] MPPIO_NIB_RESET   = 4'h0;
    // Slots of the output ports in the latch and direction arrays.
    localparam int MPPIO_P_C = 0;
    localparam int MPPIO_P_D = 1;
    localparam int MPPIO_P_E = 2;
    localparam int MPPIO_P_G = 3;
    // Port F slot, synchroniser arrays only.
    localparam int MPPIO_P_F = 4;
    // Whole state of the port block.
    typedef struct packed {
        logic            wr_pend;  // Write data phase is due.
        logic [3:0]      wr_idx;   // Register index of that write.
        logic [7:0]      rdata;    // Read data for the data phase.
        logic            opt_map;  // Option map select.
        logic [3:0][7:0] latch;    // Data latches C, D, E, G.
        logic [3:0][7:0] dir;      // Direction registers C, D, E, G.
        logic [7:0]      c_pu;     // Port C pullup control.
        logic [7:0]      c_od;     // Port C open-drain control.
        logic [3:0]      nib;      // Port G nibble controls.
        logic [4:0][7:0] s1;       // First synchroniser stage.
        logic [4:0][7:0] s2;       // Second stage.
        logic [4:0][7:0] s3;       // Third stage.
        logic [4:0][7:0] filt;     // Accepted pin levels.
    } mppio_state_t;
endpackage
`default_nettype wire

// ---- test/mppio_top_props.sv ----
// Assertions on the port block's bus and pins.
`timescale 1ns/1ps
`default_nettype none
module mppio_props (
    input wire logic        i_sys_clk,
    input wire logic        i_arst_n,
    input wire logic        i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0]  i_htrans,
    input wire logic        i_hwrite,
    input wire logic [7:0]  i_pf_in,
    input wire logic [31:0] o_hrdata,
    input wire logic        o_hreadyout,
    input wire logic [7:0]  o_pc_out,
    input wire logic [7:0]  o_pc_oe,
    input wire logic [7:0]  o_pc_pullup,
    input wire logic [7:0]  o_pd_oe,
    input wire logic [7:0]  o_pe_oe,
    input wire logic [7:0]  o_pg_out,
    input wire logic [7:0]  o_pg_oe,
    input wire logic [7:0]  o_pg_pullup,
    input wire logic        i_timer_event_output_en,
    input wire logic        i_timer_event_output,
    input wire logic        i_timer_compare_output,
    input wire logic        i_first_serial_enable,
    input wire logic        i_first_serial_master_select,
    input wire logic        i_first_serial_clock,
    input wire logic [3:0]  i_pwm_en,
    input wire logic [3:0]  i_pwm_level
);
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_arst_n);
    // Port F pins quiet through the synchroniser.
    sequence s_f_quiet;
        $stable(i_pf_in)[*6];
    endsequence
    // A port F read taken.
    sequence s_f_read;
        i_hsel && i_htrans[1] && !i_hwrite && o_hreadyout && i_haddr == 32'h14;
    endsequence
    chk_f_read_pin: assert property (s_f_quiet ##0 s_f_read |=> o_hrdata == {24'h0, $past(i_pf_in)})
        else $error("port F read differs from pin level");
    chk_c_top_od: assert property ((o_pc_oe[7:6] & o_pc_out[7:6]) == 2'b00)
        else $error("port C top bits drive high");
    chk_c_pu_low: assert property ((o_pc_pullup & o_pc_oe & ~o_pc_out) == 8'h00)
        else $error("port C pullup on a pin driven low");
    chk_g_pu_low: assert property ((o_pg_pullup & o_pg_oe & ~o_pg_out) == 8'h00)
        else $error("port G pullup on a pin driven low");
    chk_evo_drive: assert property (i_timer_event_output_en && !i_timer_event_output |-> o_pc_oe[5] && !o_pc_out[5])
        else $error("event output low not driven");
    chk_evo_level: assert property (i_timer_event_output_en && o_pc_oe[5] |-> o_pc_out[5] == i_timer_event_output)
        else $error("event output level lost");
    chk_first_serial_clock_pin_master: assert property (i_first_serial_enable && i_first_serial_master_select && !i_first_serial_clock |-> o_pc_oe[2] && !o_pc_out[2])
        else $error("serial clock not driven as master");
    chk_first_serial_in_pin_free: assert property (i_first_serial_enable |-> !o_pc_oe[0])
        else $error("serial data in pin driven");
    chk_pwm_low: assert property ((i_pwm_en & ~i_pwm_level & ~(o_pg_oe[7:4] & ~o_pg_out[7:4])) == 4'h0)
        else $error("pwm low level not on pin");
    chk_pg3_cmp: assert property (o_pg_oe[3] |-> o_pg_out[3] == i_timer_compare_output)
        else $error("pin G3 not carrying compare output");
    chk_rst_dirs: assert property ($rose(i_arst_n) |-> (o_pd_oe | o_pe_oe) == 8'h00)
        else $error("direction not cleared by reset");
endmodule
bind mppio_top mppio_props u_props (.i_sys_clk, .i_arst_n, .i_hsel, .i_haddr, .i_htrans,
    .i_hwrite, .i_pf_in, .o_hrdata, .o_hreadyout, .o_pc_out, .o_pc_oe, .o_pc_pullup, .o_pd_oe,
    .o_pe_oe, .o_pg_out, .o_pg_oe, .o_pg_pullup, .i_timer_event_output_en,
    .i_timer_event_output, .i_timer_compare_output, .i_first_serial_enable,
    .i_first_serial_master_select, .i_first_serial_clock, .i_pwm_en, .i_pwm_level);
`default_nettype wire

// ---- test/mppio_pin_model.sv ----
// Board model of one pin port.
`timescale 1ns/1ps
`default_nettype none
module mppio_pin_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_out,
    input  wire logic [7:0] i_oe,
    input  wire logic [7:0] i_pullup,
    input  wire logic [7:0] i_ext,
    input  wire logic [7:0] i_ext_en,
    output logic      [7:0] o_pin
);
    logic [7:0] float_q = 8'h5a; // Level of loose pins.
    // Loose pins toggle, so no test leans on a guess.
    always @(posedge i_clk) begin
        float_q <= ~float_q;
    end
    // Block drive wins, then outside driver, then pullup.
    assign o_pin = (i_oe & i_out) | (~i_oe & i_ext_en & i_ext)
                 | (~i_oe & ~i_ext_en & (i_pullup | float_q));
endmodule
`default_nettype wire

// ---- test/mppio_top_bench.sv ----
// Self-checking bench for the pin port block.
`timescale 1ns/1ps
`default_nettype none
module mppio_top_bench;
    import mppio_pkg::*;
    logic clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0, hready, rd_ph = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0] htrans = 2'h0, irq;
    logic evo_en = 0, timer_event_output = 0, timer_compare_output = 0, s1_en = 0, s1_ms = 0, s1_ck = 0, s1_do = 0;
    logic s2_en = 0, s2_ms = 0, s2_ck = 0, s2_do = 0, ev_in, cap_in, s1_in, s2_in, s2_ckin, s1_ckin;
    logic opt_sel;
    logic [3:0] pwm_en = 4'h0, pwm_lv = 4'h0;
    logic [7:0] pc_out, pc_oe, pc_pu, pd_out, pd_oe, pe_out, pe_oe, pg_out, pg_oe, pg_pu;
    logic [4:0][7:0] ext = '0, ext_en = '0; // Outside drivers, slots C D E G F.
    wire [4:0][7:0] pin;
    int n_mismatch = 0, tests_run = 0, cycles = 0;
    logic [31:0] exp_q[$]; // Expected reads.
    always #10 clk = ~clk;
    mppio_top dut (.i_sys_clk(clk), .i_arst_n(rst_n), .i_hsel(hsel), .i_haddr(haddr),
        .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata),
        .i_hready(hready), .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(),
        .i_pc_in(pin[0]), .o_pc_out(pc_out), .o_pc_oe(pc_oe), .o_pc_pullup(pc_pu),
        .i_pd_in(pin[1]), .o_pd_out(pd_out), .o_pd_oe(pd_oe), .i_pe_in(pin[2]),
        .o_pe_out(pe_out), .o_pe_oe(pe_oe), .i_pf_in(pin[4]), .i_pg_in(pin[3]),
        .o_pg_out(pg_out), .o_pg_oe(pg_oe), .o_pg_pullup(pg_pu),
        .i_timer_event_output_en(evo_en), .i_timer_event_output(timer_event_output),
        .i_timer_compare_output(timer_compare_output), .o_timer_event_input(ev_in),
        .o_timer_capture_input(cap_in), .o_ext_irq_level(irq),
        .i_first_serial_enable(s1_en), .i_first_serial_master_select(s1_ms),
        .i_first_serial_clock(s1_ck), .i_first_serial_out(s1_do),
        .o_first_serial_clock_in(s1_ckin), .o_first_serial_in(s1_in),
        .i_second_serial_enable(s2_en), .i_second_serial_master_select(s2_ms),
        .i_second_serial_clock(s2_ck), .i_second_serial_out(s2_do),
        .o_second_serial_clock_in(s2_ckin), .o_second_serial_in(s2_in),
        .i_pwm_en(pwm_en), .i_pwm_level(pwm_lv), .o_option_map_select(opt_sel));
    mppio_pin_model u_pc (.i_clk(clk), .i_out(pc_out), .i_oe(pc_oe), .i_pullup(pc_pu),
        .i_ext(ext[0]), .i_ext_en(ext_en[0]), .o_pin(pin[0]));
    mppio_pin_model u_pd (.i_clk(clk), .i_out(pd_out), .i_oe(pd_oe), .i_pullup(8'h0),
        .i_ext(ext[1]), .i_ext_en(ext_en[1]), .o_pin(pin[1]));
    mppio_pin_model u_pe (.i_clk(clk), .i_out(pe_out), .i_oe(pe_oe), .i_pullup(8'h0),
        .i_ext(ext[2]), .i_ext_en(ext_en[2]), .o_pin(pin[2]));
    mppio_pin_model u_pg (.i_clk(clk), .i_out(pg_out), .i_oe(pg_oe), .i_pullup(pg_pu),
        .i_ext(ext[3]), .i_ext_en(ext_en[3]), .o_pin(pin[3]));
    mppio_pin_model u_pf (.i_clk(clk), .i_out(pd_out), .i_oe(8'h0), .i_pullup(8'h0),
        .i_ext(ext[4]), .i_ext_en(ext_en[4]), .o_pin(pin[4]));
    function automatic logic [31:0] adr(input logic [3:0] idx);
        return {26'h0, idx, 2'b00};
    endfunction
    function automatic logic [31:0] z(input logic [7:0] v);
        return {24'h0, v};
    endfunction
    // Counts and compares one result.
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One transfer, entered after a rising edge.
    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= a;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hready !== 1'b1);
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        bus(a, 1'b1, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        bus(a, 1'b0, 32'h0);
    endtask
    task automatic map(input logic m);
        wr(adr(MPPIO_IDX_CONFIG), z(8'(m) << MPPIO_CFG_OPTION_MAP_BIT));
    endtask
    // Waits n edges, then samples at the falling edge.
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    // Oldest note is due at the edge ending a read data phase.
    always @(posedge clk) begin
        if (rd_ph && hready && exp_q.size() > 0) check(hrdata, exp_q.pop_front());
        if (hready) rd_ph <= hsel && htrans[1] && !hwrite;
    end
    // Cuts a hang far beyond the tests' roughly 150 cycles.
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    initial begin
        logic [7:0] r, w, e;
        void'($urandom(32'h4fc2bf36));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        settle(2);
        check({pc_oe, pd_oe, pe_oe, pg_oe}, 32'h0);
        @(posedge clk);
        wr(adr(MPPIO_IDX_D_DATA), 32'hff); // Latch, not direction.
        settle(0);
        check(z(pd_oe), 32'h0);
        @(posedge clk);
        map(1'b1);
        settle(0);
        check(z(opt_sel), 32'h1);
        @(posedge clk);
        for (int i = 2; i < 7; i++) if (i != 5) rd(adr(4'(i)), 32'h0);
        rd(32'h100, 32'h0); // Unmapped place reads zero.
        $display("test reset done");
        // Ports D and E, random directions, latches, board levels.
        for (int p = 0; p < 2; p++) begin
            r = $urandom();
            w = $urandom();
            e = $urandom();
            ext[1+p] <= e;
            ext_en[1+p] <= ~r; // Board drives only the inputs.
            wr(adr(4'(MPPIO_IDX_D_DIR + p)), z(r));
            map(1'b0);
            wr(adr(4'(MPPIO_IDX_D_DATA + p)), z(w));
            settle(5);
            check(z(p ? pe_oe : pd_oe), z(r));
            check(z((p ? pe_out : pd_out) & r), z(w & r));
            @(posedge clk);
            rd(adr(4'(MPPIO_IDX_D_DATA + p)), z((w & r) | (e & ~r)));
            map(1'b1);
        end
        $display("test ports d e done");
        e = $urandom();
        ext[4] <= e;
        ext_en[4] <= 8'hff;
        map(1'b0);
        wr(adr(MPPIO_IDX_F_LEVELS), z(~e));
        settle(6);
        @(posedge clk);
        rd(adr(MPPIO_IDX_F_LEVELS), z(e));
        $display("test port f done");
        // Port C: open-drain top bits, event output, first serial interface.
        ext[0] <= 8'h15;
        ext_en[0] <= 8'h1f;
        wr(adr(MPPIO_IDX_C_PULLUP), 32'hff);
        wr(adr(MPPIO_IDX_C_DATA), 32'h80);
        map(1'b1);
        wr(adr(MPPIO_IDX_C_DIR), 32'he0);
        map(1'b0);
        settle(6);
        check(z(pc_oe), 32'h60);
        check(z(pc_out & pc_oe), 32'h0);
        check(z(pc_pu), 32'h9f);
        check({30'h0, irq}, 32'h2);
        check({30'h0, ev_in, cap_in}, 32'h2);
        @(posedge clk);
        rd(adr(MPPIO_IDX_C_DATA), 32'h95);
        evo_en <= 1'b1;
        timer_event_output <= 1'b1;
        s1_en <= 1'b1;
        s1_ms <= 1'b1;
        s1_do <= 1'b1;
        settle(6);
        check(z(pc_oe), 32'h66);
        check(z(pc_out & pc_oe), 32'h22);
        check(z(pc_pu), 32'hbb);
        check({30'h0, s1_ckin, s1_in}, 32'h1);
        @(posedge clk);
        rd(adr(MPPIO_IDX_C_DATA), 32'h93);
        wr(adr(MPPIO_IDX_C_OD), 32'h22);
        settle(0);
        check(z(pc_oe), 32'h44);
        @(posedge clk);
        timer_event_output <= 1'b0;
        map(1'b1);
        wr(adr(MPPIO_IDX_C_DIR), 32'he7);
        map(1'b0);
        settle(6);
        check(z(pc_oe), 32'h64);
        @(posedge clk);
        rd(adr(MPPIO_IDX_C_DATA), 32'h90);
        evo_en <= 1'b0;
        s1_en <= 1'b0;
        $display("test port c done");
        // Port G: compare output, pwm, second serial slave, nibble controls.
        map(1'b1);
        wr(adr(MPPIO_IDX_G_DIR), 32'h08);
        map(1'b0);
        wr(adr(MPPIO_IDX_G_DATA), 32'h0);
        timer_compare_output <= 1'b1;
        pwm_en <= 4'h8;
        s2_en <= 1'b1;
        ext[3] <= 8'h55;
        ext_en[3] <= 8'h75;
        settle(6);
        check(z(pg_oe), 32'h8a);
        check(z(pg_out & pg_oe), 32'h08);
        check({30'h0, s2_ckin, s2_in}, 32'h3);
        @(posedge clk);
        rd(adr(MPPIO_IDX_G_DATA), 32'h5d);
        wr(adr(MPPIO_IDX_NIBBLE), 32'h6);
        pwm_lv <= 4'h8;
        settle(2);
        check(z(pg_oe & 8'hf0), 32'h0);
        check(z(pg_pu), 32'h0d);
        $display("test port g done");
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        settle(1);
        check(z(pd_oe | pe_oe | pc_oe), 32'h0);
        $display("test second reset done");
        settle(2);
        summarize();
    end
endmodule
`default_nettype wire
